// >>> hw/jdp_defines.vh
`ifndef JDP_DEFINES_VH
`define JDP_DEFINES_VH

// TAP state encodings
`define JDP_ST_RESET      4'h0
`define JDP_ST_IDLE       4'h1
`define JDP_ST_SEL_DR     4'h2
`define JDP_ST_CAP_DR     4'h3
`define JDP_ST_SHIFT_DR   4'h4
`define JDP_ST_EXIT1_DR   4'h5
`define JDP_ST_PAUSE_DR   4'h6
`define JDP_ST_EXIT2_DR   4'h7
`define JDP_ST_UPD_DR     4'h8
`define JDP_ST_SEL_IR     4'h9
`define JDP_ST_CAP_IR     4'ha
`define JDP_ST_SHIFT_IR   4'hb
`define JDP_ST_EXIT1_IR   4'hc
`define JDP_ST_PAUSE_IR   4'hd
`define JDP_ST_EXIT2_IR   4'he
`define JDP_ST_UPD_IR     4'hf

// Capture values loaded into the shift paths
`define JDP_IR_CAPTURE    4'h1
`define JDP_DR_CAPTURE    32'h0000_0000

// Cycles from detected debug request to acknowledge pull, and cycles the pull lasts
`define JDP_ACK_DELAY     8'h04

`endif

// >>> hw/jdp_port.v
// Overview of operation
// - All test logic shifts on test clock
// - Data in captured on rising test clock
// - Mode select sampled each rising edge
// - Data out driven in shift states and on into Exit1 until the next falling edge
// - Data out changes on falling edges
// - Low test reset resets the TAP
// - Debug event line is open drain
// - Pulled-low event line requests debug entry
// - Device pulls event line low to acknowledge
`timescale 1ns/1ns
`include "jdp_defines.vh"

module jdp_port #(
    parameter IR_W = 4,
    parameter DR_W = 32
) (
    input wire clk,
    input wire rst,
    input wire tck,
    input wire tms,
    input wire tdi,
    input wire trst_n,
    output reg tdo_o,
    output reg tdo_oe_n,
    input wire debug_event_n_i,
    output reg debug_event_n_o,
    output reg debug_event_n_oe_n,
    output reg debug_mode,
    output reg [IR_W-1:0] ir_q,
    output reg [3:0] tap_state_q
);

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    // Bit order of the pin vectors, from bit 0 upward
    localparam NUM_PINS = 4;
    localparam PIN_TCK = 0;
    localparam PIN_TMS = 1;
    localparam PIN_TDI = 2;
    localparam PIN_TRST = 3;

    wire [NUM_PINS-1:0] pin_raw;
    wire [NUM_PINS-1:0] pin_sync;
    reg [1:0] dbg_s_q;
    reg tck_prev_q;
    reg [7:0] ack_cnt_q;
    reg [IR_W-1:0] ir_sh_q;
    reg [DR_W-1:0] dr_sh_q;
    reg [3:0] st_d;
    wire tms_sync;
    wire tdi_sync;
    wire tck_rise;
    wire tck_fall;
    wire trst_act;
    wire shifting;

    assign pin_raw = {trst_n, tdi, tms, tck};

    // Test pins are kept out of system reset on purpose: a system reset
    // alone must not disturb the TAP, only the test reset may
    genvar g;
    generate
        for (g = 0; g < NUM_PINS; g = g + 1) begin : g_pin_sync
            reg [1:0] sync_q;
            always @(posedge clk) begin
                sync_q <= {sync_q[0], pin_raw[g]};
            end
            assign pin_sync[g] = sync_q[1];
        end
    endgenerate

    // Event line idles high, so its synchroniser resets high
    always @(posedge clk) begin
        if (rst) begin
            dbg_s_q <= 2'h3;
        end else begin
            dbg_s_q <= {dbg_s_q[0], debug_event_n_i};
        end
    end

    // Previous test clock level; follows the pin only
    always @(posedge clk) begin
        tck_prev_q <= pin_sync[PIN_TCK];
    end

    assign tms_sync = pin_sync[PIN_TMS];
    assign tdi_sync = pin_sync[PIN_TDI];
    // Edges of the test clock, found on the system clock
    assign tck_rise = pin_sync[PIN_TCK] & ~tck_prev_q;
    assign tck_fall = ~pin_sync[PIN_TCK] & tck_prev_q;
    // Only the test reset clears the TAP
    assign trst_act = ~pin_sync[PIN_TRST];
    assign shifting = (tap_state_q == `JDP_ST_SHIFT_DR) || (tap_state_q == `JDP_ST_SHIFT_IR);

    // ------------------------------------------------------------
    // TAP state machine
    // ------------------------------------------------------------
    always @* begin
        case (tap_state_q)
            `JDP_ST_RESET: st_d = tms_sync ? `JDP_ST_RESET : `JDP_ST_IDLE;
            `JDP_ST_IDLE: st_d = tms_sync ? `JDP_ST_SEL_DR : `JDP_ST_IDLE;
            `JDP_ST_SEL_DR: st_d = tms_sync ? `JDP_ST_SEL_IR : `JDP_ST_CAP_DR;
            `JDP_ST_CAP_DR: st_d = tms_sync ? `JDP_ST_EXIT1_DR : `JDP_ST_SHIFT_DR;
            `JDP_ST_SHIFT_DR: st_d = tms_sync ? `JDP_ST_EXIT1_DR : `JDP_ST_SHIFT_DR;
            `JDP_ST_EXIT1_DR: st_d = tms_sync ? `JDP_ST_UPD_DR : `JDP_ST_PAUSE_DR;
            `JDP_ST_PAUSE_DR: st_d = tms_sync ? `JDP_ST_EXIT2_DR : `JDP_ST_PAUSE_DR;
            `JDP_ST_EXIT2_DR: st_d = tms_sync ? `JDP_ST_UPD_DR : `JDP_ST_SHIFT_DR;
            `JDP_ST_UPD_DR: st_d = tms_sync ? `JDP_ST_SEL_DR : `JDP_ST_IDLE;
            `JDP_ST_SEL_IR: st_d = tms_sync ? `JDP_ST_RESET : `JDP_ST_CAP_IR;
            `JDP_ST_CAP_IR: st_d = tms_sync ? `JDP_ST_EXIT1_IR : `JDP_ST_SHIFT_IR;
            `JDP_ST_SHIFT_IR: st_d = tms_sync ? `JDP_ST_EXIT1_IR : `JDP_ST_SHIFT_IR;
            `JDP_ST_EXIT1_IR: st_d = tms_sync ? `JDP_ST_UPD_IR : `JDP_ST_PAUSE_IR;
            `JDP_ST_PAUSE_IR: st_d = tms_sync ? `JDP_ST_EXIT2_IR : `JDP_ST_PAUSE_IR;
            `JDP_ST_EXIT2_IR: st_d = tms_sync ? `JDP_ST_UPD_IR : `JDP_ST_SHIFT_IR;
            `JDP_ST_UPD_IR: st_d = tms_sync ? `JDP_ST_SEL_DR : `JDP_ST_IDLE;
            default: st_d = `JDP_ST_RESET;
        endcase
    end

    always @(posedge clk) begin
        // A system reset on its own leaves the TAP where it was, so a
        // debugger holding the port keeps its place across it
        if (trst_act) begin
            tap_state_q <= `JDP_ST_RESET;
            ir_sh_q <= {IR_W{1'b0}};
            ir_q <= {IR_W{1'b0}};
            dr_sh_q <= {DR_W{1'b0}};
        end else if (tck_rise) begin
            tap_state_q <= st_d;
            case (tap_state_q)
                `JDP_ST_RESET: ir_q <= {IR_W{1'b0}};
                `JDP_ST_CAP_IR: ir_sh_q <= `JDP_IR_CAPTURE;
                // Both shift paths move toward bit 0, which feeds tdo
                `JDP_ST_SHIFT_IR: ir_sh_q <= {tdi_sync, ir_sh_q[IR_W-1:1]};
                `JDP_ST_UPD_IR: ir_q <= ir_sh_q;
                `JDP_ST_CAP_DR: dr_sh_q <= `JDP_DR_CAPTURE;
                `JDP_ST_SHIFT_DR: dr_sh_q <= {tdi_sync, dr_sh_q[DR_W-1:1]};
                default: ir_q <= ir_q;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Serial data out
    // ------------------------------------------------------------
    // Updated on the falling edge so it is settled at the next rise
    always @(posedge clk) begin
        // Released while the test reset holds the TAP
        if (trst_act) begin
            tdo_o <= 1'b0;
            tdo_oe_n <= 1'b1;
        end else if (tck_fall) begin
            tdo_oe_n <= ~shifting;
            if (tap_state_q == `JDP_ST_SHIFT_IR)
                tdo_o <= ir_sh_q[0];
            else if (tap_state_q == `JDP_ST_SHIFT_DR)
                tdo_o <= dr_sh_q[0];
        end
    end

    // ------------------------------------------------------------
    // Debug event handshake
    // ------------------------------------------------------------
    // Phases of the handshake
    localparam DBG_IDLE = 2'h0;
    localparam DBG_WAIT = 2'h1;
    localparam DBG_ACK = 2'h2;
    localparam DBG_DONE = 2'h3;

    reg [1:0] dbg_ph_q;

    // Output only ever drives low; release means enable off.
    // One entry per system reset: later pulls on the line are ignored,
    // which also keeps our own acknowledge from looking like a request.
    always @(posedge clk) begin
        if (rst) begin
            dbg_ph_q <= DBG_IDLE;
            ack_cnt_q <= 8'h00;
            debug_mode <= 1'b0;
            debug_event_n_o <= 1'b0;
            debug_event_n_oe_n <= 1'b1;
        end else begin
            debug_event_n_o <= 1'b0;
            case (dbg_ph_q)
                DBG_IDLE: begin
                    ack_cnt_q <= 8'h00;
                    if (!dbg_s_q[1]) begin
                        dbg_ph_q <= DBG_WAIT;
                    end
                end
                DBG_WAIT: begin
                    if (ack_cnt_q == `JDP_ACK_DELAY - 8'h01) begin
                        debug_mode <= 1'b1;
                        debug_event_n_oe_n <= 1'b0;
                        ack_cnt_q <= 8'h00;
                        dbg_ph_q <= DBG_ACK;
                    end else begin
                        ack_cnt_q <= ack_cnt_q + 8'h01;
                    end
                end
                DBG_ACK: begin
                    if (ack_cnt_q == `JDP_ACK_DELAY - 8'h01) begin
                        // Let go so the debugger sees the line rise again
                        debug_event_n_oe_n <= 1'b1;
                        dbg_ph_q <= DBG_DONE;
                    end else begin
                        ack_cnt_q <= ack_cnt_q + 8'h01;
                    end
                end
                default: begin
                    dbg_ph_q <= DBG_DONE;
                end
            endcase
        end
    end

endmodule // jdp_port

// >>> test/jdp_port_monitor.sv
`timescale 1ns/1ns
module jdp_port_monitor (
    input wire clk,
    input wire rst,
    input wire tck,
    input wire trst_n,
    input wire tdo_o,
    input wire tdo_oe_n,
    input wire debug_event_n_i,
    input wire debug_event_n_o,
    input wire debug_event_n_oe_n,
    input wire debug_mode,
    input wire [3:0] tap_state_q
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // ----
    // Debug handshake
    // ----
    sequence s_req;
        !debug_mode && $fell(debug_event_n_i);
    endsequence
    sequence s_ack;
        ##[5:9] !debug_event_n_oe_n [*4] ##1 debug_event_n_oe_n;
    endsequence
    a_ack_pulse: assert property (s_req |-> s_ack)
        else $error("ack pulse wrong");
    a_ack_cause: assert property ($fell(debug_event_n_oe_n) |-> debug_mode)
        else $error("ack without debug mode");
    a_open_drain: assert property (!debug_event_n_oe_n |-> !debug_event_n_o)
        else $error("event line driven high");
    a_mode_sticky: assert property (debug_mode |=> debug_mode)
        else $error("debug mode dropped");
    // ----
    // Test port
    // ----
    a_tdo_enable: assert property (!tdo_oe_n && trst_n |-> tap_state_q inside {4'h4, 4'h5, 4'hb, 4'hc})
        else $error("tdo driven outside shift");
    a_tdo_fall: assert property (($changed(tdo_o) || $changed(tdo_oe_n)) && trst_n |-> !$past(tck, 2))
        else $error("tdo moved off falling edge");
    a_state_rise: assert property ($changed(tap_state_q) && trst_n && $past(trst_n, 4) |-> $past(tck, 2))
        else $error("state moved off rising edge");
    a_trst_reset: assert property (!trst_n [*5] |-> tap_state_q == 4'h0 && tdo_oe_n)
        else $error("test reset ignored");
    a_idle_exit: assert property ($changed(tap_state_q) && $past(tap_state_q) == 4'h1 && trst_n |-> tap_state_q == 4'h2)
        else $error("bad exit from idle");
endmodule // jdp_port_monitor
bind jdp_port jdp_port_monitor jdp_port_monitor_i (.clk, .rst, .tck, .trst_n, .tdo_o, .tdo_oe_n,
    .debug_event_n_i, .debug_event_n_o, .debug_event_n_oe_n, .debug_mode, .tap_state_q);

// >>> test/jdp_dbg_model.sv
`timescale 1ns/1ns
module jdp_dbg_model (
    input wire clk,
    input wire tdo_o,
    input wire tdo_oe_n,
    input wire dev_o,
    input wire dev_oe_n,
    output reg tck,
    output reg tms,
    output reg tdi,
    output reg trst_n,
    output wire event_n
);
    reg pull_q = 1'b0;
    reg last_q = 1'b0;
    // ----
    // Line levels
    // ----
    // Pull-up wins unless a side pulls low
    assign event_n = ~pull_q & (dev_oe_n | dev_o);
    // Released tdo must not read as a stale bit
    wire tdo_w = tdo_oe_n ? ~last_q : tdo_o;
    always @(posedge clk) last_q <= tdo_w;
    initial {tck, tms, tdi, trst_n} = 4'h6;
    task bit_cycle(input reg m, input reg d, output reg q);
        begin
            @(posedge clk);
            tms <= m;
            tdi <= d;
            repeat (9) @(posedge clk);
            q = tdo_w;
            tck <= 1'b1;
            repeat (10) @(posedge clk);
            tck <= 1'b0;
        end
    endtask
    task drive(input reg t, input reg p);
        begin
            @(posedge clk);
            trst_n <= t;
            pull_q <= p;
        end
    endtask
endmodule // jdp_dbg_model

// >>> test/tb.sv
`timescale 1ns/1ns
`include "jdp_defines.vh"
module tb;
    reg clk = 1'b0;
    reg rst = 1'b1;
    integer seed = 61, num_errors = 0, n_tests = 0, cyc = 0, i, k;
    reg [3:0] ins, got;
    reg q;
    wire tck, tms, tdi, trst_n, tdo_o, tdo_oe_n, ev_n, ev_o, ev_oe_n, debug_mode;
    wire [3:0] ir_q, tap_state_q;
    always #4 clk = ~clk;
    jdp_port jdp_port_i (.clk(clk), .rst(rst), .tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n),
        .tdo_o(tdo_o), .tdo_oe_n(tdo_oe_n), .debug_event_n_i(ev_n), .debug_event_n_o(ev_o),
        .debug_event_n_oe_n(ev_oe_n), .debug_mode(debug_mode), .ir_q(ir_q), .tap_state_q(tap_state_q));
    jdp_dbg_model jdp_dbg_model_i (.clk(clk), .tdo_o(tdo_o), .tdo_oe_n(tdo_oe_n), .dev_o(ev_o),
        .dev_oe_n(ev_oe_n), .tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n), .event_n(ev_n));
    task check(input [7:0] g, input [7:0] e);
        begin
            #1 n_tests = n_tests + 1;
            if (g !== e) begin
                num_errors = num_errors + 1;
                $display("Error at %0t: got %h expected %h", $time, g, e);
            end
        end
    endtask
    task close_out;
        begin
            $display("Checks %0d errors %0d", n_tests, num_errors);
            if (num_errors == 0 && n_tests > 0)
                $display("*** PASS ***");
            else
                $display("*** FAIL ***");
            $finish;
        end
    endtask
    task go(input [7:0] v, input integer n);
        for (k = 0; k < n; k = k + 1)
            jdp_dbg_model_i.bit_cycle(v[k], 1'b1, q);
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 9000) begin
            num_errors = num_errors + 1;
            close_out;
        end
    end
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        jdp_dbg_model_i.drive(1'b1, 1'b0);
        for (i = 0; i < 6; i = i + 1) begin
            ins = (i == 0) ? 4'h0 : (i == 1) ? 4'hf : $random(seed);
            go(8'h1f, 5);
            check(tap_state_q, `JDP_ST_RESET);
            go(8'h06, 5);
            check(tap_state_q, `JDP_ST_SHIFT_IR);
            for (k = 0; k < 4; k = k + 1)
                jdp_dbg_model_i.bit_cycle(k == 3, ins[k], got[k]);
            check(got, `JDP_IR_CAPTURE);
            go(8'h01, 2);
            check(ir_q, ins);
            check(tdo_oe_n, 1'b1);
        end
        go(8'h03, 5);
        jdp_dbg_model_i.drive(1'b0, 1'b0);
        repeat (6) @(posedge clk);
        check({tdo_oe_n, tap_state_q}, 5'h10);
        jdp_dbg_model_i.drive(1'b1, 1'b1);
        for (k = 0; k < 12 && ev_oe_n !== 1'b0; k = k + 1) @(posedge clk);
        check(debug_mode, 1'b1);
        jdp_dbg_model_i.drive(1'b1, 1'b0);
        @(posedge clk);
        check(ev_n, 1'b0);
        repeat (8) @(posedge clk);
        jdp_dbg_model_i.drive(1'b1, 1'b1);
        repeat (15) @(posedge clk);
        check(ev_oe_n, 1'b1);
        jdp_dbg_model_i.drive(1'b1, 1'b0);
        go(8'h00, 1);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        check(debug_mode, 1'b0);
        check(tap_state_q, `JDP_ST_IDLE);
        close_out;
    end
endmodule // tb
